// ### hdl/csp_defines.vh
// constants of the two-channel clocked serial port
// assumes byte-wide register strobes from the host processor core
`ifndef CSP_DEFINES_VH
`define CSP_DEFINES_VH

// register byte addresses
`define CSP_MODE_CH0_ADDR 16'hFF80
`define CSP_MODE_CH1_ADDR 16'hFF88
`define CSP_OFS_CLKSEL    16'h0001
`define CSP_OFS_SHIFT     16'h0002
`define CSP_OFS_TXBUF     16'h0003

// mode control register fields
`define CSP_MODE_EN_BIT   7
`define CSP_MODE_TRX_BIT  6
`define CSP_MODE_SSE_BIT  5
`define CSP_MODE_DIR_BIT  4
`define CSP_MODE_ACT_BIT  0

// clock select register fields
`define CSP_CLK_CKP_BIT   4
`define CSP_CLK_DAP_BIT   3
`define CSP_CLK_CKS_HI    2
`define CSP_CLK_CKS_LO    0

// reset values and codes
`define CSP_MODE_RST      8'h00
`define CSP_CLKSEL_RST    8'h00
`define CSP_CKS_SLAVE     3'h7
`define CSP_BITS_LAST     4'h7
`define CSP_BITS_FULL     4'h8
`define CSP_EDGES_LAST    4'hF

`endif

// ### hdl/csp_fifo.v
// small synchronous fifo with valid/ready on both sides
// assumes one clock; read data follow the read pointer
`timescale 1ns/1ps
module csp_fifo #(
  parameter W  = 8,
  parameter D  = 4,
  parameter AW = 2
) (
  input  wire          clk,
  input  wire          rst_b,
  input  wire [W-1:0]  in_data,
  input  wire          in_valid,
  output wire          in_ready,
  output wire [W-1:0]  out_data,
  output wire          out_valid,
  input  wire          out_ready
);
  localparam [AW:0] DEPTH_W = D;

  reg  [W-1:0]  mem [0:D-1];
  reg  [AW-1:0] wp_reg;
  reg  [AW-1:0] rp_reg;
  reg  [AW:0]   cnt_reg;
  reg  [AW:0]   cnt_next;
  reg           ready_reg;
  reg           valid_reg;
  wire          push;
  wire          pop;

  assign push      = in_valid & ready_reg;
  assign pop       = out_ready & valid_reg;
  assign in_ready  = ready_reg;
  assign out_valid = valid_reg;
  assign out_data  = mem[rp_reg];

  // occupancy; full and empty kept as flops so in_ready and out_valid are clean
  always @* begin
    cnt_next = cnt_reg;
    if (push & ~pop)
      cnt_next = cnt_reg + {{AW{1'b0}}, 1'b1};
    else if (pop & ~push)
      cnt_next = cnt_reg - {{AW{1'b0}}, 1'b1};
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_reg    <= {AW{1'b0}};
      rp_reg    <= {AW{1'b0}};
      cnt_reg   <= {(AW+1){1'b0}};
      ready_reg <= 1'b1;
      valid_reg <= 1'b0;
    end else begin
      if (push)
        wp_reg <= wp_reg + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
        rp_reg <= rp_reg + {{(AW-1){1'b0}}, 1'b1};
      cnt_reg   <= cnt_next;
      ready_reg <= (cnt_next != DEPTH_W);
      valid_reg <= (cnt_next != {(AW+1){1'b0}});
    end
  end

  // storage has no reset; only written words are ever read
  always @(posedge clk) begin
    if (push)
      mem[wp_reg] <= in_data;
  end
endmodule

// ### hdl/csp_top.v
// two-channel 8-bit clocked serial port with byte-wide registers
// assumes synchronous pins and a host that obeys the busy flag
`timescale 1ns/1ps
`include "csp_defines.vh"
module csp_top #(
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW    = 2
) (
  input  wire        clk,
  input  wire        rst_b,
  input  wire [15:0] addr,
  input  wire [7:0]  wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [7:0]  rdata,
  input  wire [1:0]  sck_in,
  input  wire [1:0]  si_in,
  input  wire        ss_in_b,
  output wire [1:0]  sck_o,
  output wire [1:0]  sck_oe,
  output wire [1:0]  so_o,
  output wire [1:0]  so_oe,
  output wire [1:0]  done_flag,
  input  wire [1:0]  done_clr,
  output wire [1:0]  tx_ready
);
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RUN  = 2'b10;

  reg  [6:0]  pre_reg;
  wire [15:0] mode_v;
  wire [15:0] clk_v;
  wire [15:0] sh_v;

  // free prescaler shared by both channels
  // one shared count keeps both channels' ticks on the same phase
  // divider base count
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      pre_reg <= 7'h00;
    else
      pre_reg <= pre_reg + 7'h01;
  end

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : ch
      localparam [15:0] BASE = (i == 1) ? `CSP_MODE_CH1_ADDR
                                        : `CSP_MODE_CH0_ADDR;
      reg        en_reg;
      reg        trx_reg;
      reg        sse_reg;
      reg        dir_reg;
      reg        ckp_reg;
      reg        dap_reg;
      reg  [2:0] cks_reg;
      reg  [1:0] st_reg;
      reg  [7:0] sh_reg;
      reg  [3:0] bit_reg;
      reg  [3:0] edg_reg;
      reg        so_reg;
      reg        sck_reg;
      reg        prev_reg;
      reg        pend_reg;
      reg        done_reg;
      reg        sckoe_reg;
      reg        sooe_reg;
      wire       ch_rst_b;
      wire       slave;
      wire       hold;
      wire       idle_lvl;
      wire [6:0] mask;
      wire       tick;
      wire       run;
      wire       lead;
      wire       trail;
      wire       samp;
      wire       shout;
      wire       fin;
      wire       f_valid;
      wire [7:0] f_data;
      wire       start_tx;
      wire       start_rx;
      wire       out_bit;
      wire       first_bit;

      // channel reset path
      // clearing enable resets the shifter side without a clock
      assign ch_rst_b = rst_b & en_reg;
      assign slave    = (cks_reg == `CSP_CKS_SLAVE);
      // a held frame keeps its counters, so bits shifted before a deselect are kept
      // select gating
      assign hold     = (i == 1) & sse_reg & slave & ss_in_b;
      // idle level
      // polarity 0 idles the clock high, so type one after reset
      assign idle_lvl = ~ckp_reg;
      // power of two
      // a tick every 2^cks cycles gives a clock period of 2^(cks+1)
      assign mask     = ~(7'h7F << cks_reg);
      assign tick     = ((pre_reg & mask) == mask) & ~slave;
      assign run      = st_reg[1] & ~hold;
      // edges that arrive while held are dropped, never queued
      // suspend on select
      assign lead  = run & (slave ? (sck_in[i] != idle_lvl &&
                                     prev_reg == idle_lvl)
                                  : (tick && sck_reg == idle_lvl));
      assign trail = run & (slave ? (sck_in[i] == idle_lvl &&
                                     prev_reg != idle_lvl)
                                  : (tick && sck_reg != idle_lvl));
      assign samp  = dap_reg ? lead : trail;
      assign shout = dap_reg ? trail : lead;
      // end of frame
      // master finishes on its sixteenth edge so the clock ends idle
      assign fin   = slave ? (samp && bit_reg == `CSP_BITS_LAST)
                           : (run && tick && edg_reg == `CSP_EDGES_LAST);
      assign out_bit   = dir_reg ? sh_reg[0] : sh_reg[7];
      assign first_bit = dir_reg ? f_data[0] : f_data[7];
      assign start_tx = st_reg[0] & en_reg & trx_reg & f_valid & ~hold;
      assign start_rx = st_reg[0] & en_reg & ~trx_reg & pend_reg & ~hold;

      // buffer writes queue here until the channel is free
      csp_fifo #(
        .W  (8),
        .D  (FIFO_DEPTH),
        .AW (FIFO_AW)
      ) u_txq (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_data   (wdata),
        .in_valid  (wr && addr == BASE + `CSP_OFS_TXBUF),
        .in_ready  (tx_ready[i]),
        .out_data  (f_data),
        .out_valid (f_valid),
        .out_ready (start_tx)
      );

      // control reset
      // control and clock select registers
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          en_reg  <= 1'b0;
          trx_reg <= 1'b0;
          sse_reg <= 1'b0;
          dir_reg <= 1'b0;
          ckp_reg <= 1'b0;
          dap_reg <= 1'b0;
          cks_reg <= 3'h0;
        end else begin
          if (wr && addr == BASE) begin
            en_reg  <= wdata[`CSP_MODE_EN_BIT];
            trx_reg <= wdata[`CSP_MODE_TRX_BIT];
            sse_reg <= (i == 1) & wdata[`CSP_MODE_SSE_BIT];
            dir_reg <= wdata[`CSP_MODE_DIR_BIT];
          end
          if (wr && addr == BASE + `CSP_OFS_CLKSEL) begin
            ckp_reg <= wdata[`CSP_CLK_CKP_BIT];
            dap_reg <= wdata[`CSP_CLK_DAP_BIT];
            cks_reg <= wdata[`CSP_CLK_CKS_HI:`CSP_CLK_CKS_LO];
          end
        end
      end

      always @(posedge clk or negedge ch_rst_b) begin
        if (!ch_rst_b) begin
          st_reg   <= ST_IDLE;
          sh_reg   <= 8'h00;
          bit_reg  <= 4'h0;
          edg_reg  <= 4'h0;
          so_reg   <= 1'b0;
          sck_reg  <= 1'b1;
          pend_reg <= 1'b0;
        end else begin
          // a shifter read with tx/rx select at 1 arms nothing
          if (rd && addr == BASE + `CSP_OFS_SHIFT && !trx_reg)
            pend_reg <= 1'b1;
          else if (start_rx)
            pend_reg <= 1'b0;
          case (st_reg)
            ST_IDLE: begin
              sck_reg <= idle_lvl;
              if (~trx_reg)
                so_reg <= 1'b0;
              if (start_tx | start_rx) begin
                st_reg  <= ST_RUN;
                bit_reg <= 4'h0;
                edg_reg <= 4'h0;
                if (start_tx)
                  sh_reg <= f_data;
                // first bit goes out at once for the late phase
                if (dap_reg)
                  so_reg <= trx_reg & first_bit;
              end
            end
            ST_RUN: begin
              if (tick && !hold) begin
                sck_reg <= ~sck_reg;
                edg_reg <= edg_reg + 4'h1;
              end
              if (samp) begin
                bit_reg <= bit_reg + 4'h1;
                sh_reg  <= dir_reg ? {si_in[i], sh_reg[7:1]}
                                   : {sh_reg[6:0], si_in[i]};
              end
              if (shout && bit_reg != `CSP_BITS_FULL)
                so_reg <= trx_reg & out_bit;
              if (fin)
                st_reg <= ST_IDLE;
            end
            default: st_reg <= ST_IDLE;
          endcase
        end
      end

      // slave clock history, pin enables and completion flag
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          prev_reg  <= 1'b1;
          done_reg  <= 1'b0;
          sckoe_reg <= 1'b0;
          sooe_reg  <= 1'b0;
        end else begin
          prev_reg  <= sck_in[i];
          // done flag, set wins over clear
          done_reg  <= (fin & st_reg[1]) | (done_reg & ~done_clr[i]);
          sckoe_reg <= en_reg & ~slave;
          sooe_reg  <= en_reg & trx_reg;
        end
      end

      assign sck_o[i]     = sck_reg;
      assign sck_oe[i]    = sckoe_reg;
      assign so_o[i]      = so_reg;
      assign so_oe[i]     = sooe_reg;
      assign done_flag[i] = done_reg;
      assign mode_v[8*i+7:8*i] = {en_reg, trx_reg, sse_reg, dir_reg,
                                  3'h0, st_reg[1]};
      assign clk_v[8*i+7:8*i]  = {3'h0, ckp_reg, dap_reg, cks_reg};
      assign sh_v[8*i+7:8*i]   = sh_reg;
    end
  endgenerate

  // registered read data; unmapped addresses return zero
  // the shifter read arms reception inside the channel, not here
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      rdata <= 8'h00;
    else if (rd) begin
      case (addr)
        `CSP_MODE_CH0_ADDR:                   rdata <= mode_v[7:0];
        `CSP_MODE_CH0_ADDR + `CSP_OFS_CLKSEL: rdata <= clk_v[7:0];
        `CSP_MODE_CH0_ADDR + `CSP_OFS_SHIFT:  rdata <= sh_v[7:0];
        `CSP_MODE_CH1_ADDR:                   rdata <= mode_v[15:8];
        `CSP_MODE_CH1_ADDR + `CSP_OFS_CLKSEL: rdata <= clk_v[15:8];
        `CSP_MODE_CH1_ADDR + `CSP_OFS_SHIFT:  rdata <= sh_v[15:8];
        default:                              rdata <= 8'h00;
      endcase
    end
  end
endmodule

// ### tb/csp_props_properties.sv
// checker for the serial port pins and register strobes
// assumes clock polarity 0 on channel 0 while frames run
`timescale 1ns/1ps
module csp_props (
  input wire        clk,
  input wire        rst_b,
  input wire [15:0] addr,
  input wire [7:0]  wdata,
  input wire        wr,
  input wire        ss_in_b,
  input wire [1:0]  sck_o,
  input wire [1:0]  sck_oe,
  input wire [1:0]  so_o,
  input wire [1:0]  so_oe,
  input wire [1:0]  done_flag,
  input wire [1:0]  done_clr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  reg [3:0] tog_reg;
  reg       prev_reg;
  // clock edges within the frame; cleared while the clock is not driven
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tog_reg  <= 4'h0;
      prev_reg <= 1'h1;
    end else begin
      tog_reg  <= sck_oe[0] ? tog_reg + {3'h0, sck_o[0] ^ prev_reg} : 4'h0;
      prev_reg <= sck_o[0];
    end
  end
  sequence s_stop0;
    wr && addr == 16'hFF80 && !wdata[7];
  endsequence
  sequence s_rxonly0;
    wr && addr == 16'hFF80 && wdata[7:6] == 2'h2;
  endsequence
  a_reset_quiet:
    assert property ($rose(rst_b) |-> !sck_oe && !so_oe && !done_flag)
    else $error("pins driven after reset");
  a_stop_release:
    assert property (s_stop0 |-> ##2 !sck_oe[0] && !so_oe[0] && !so_o[0])
    else $error("channel 0 still driving after stop");
  a_ch1_release:
    assert property (wr && addr == 16'hFF88 && !wdata[7] |->
      ##2 !sck_oe[1] && !so_o[1]) else $error("channel 1 not released");
  a_rx_out_low:
    assert property (s_rxonly0 |-> ##2 !so_o[0] && !so_oe[0])
    else $error("data out not low in receive mode");
  a_frame_edges:
    assert property ($rose(done_flag[0]) && sck_oe[0] |=> tog_reg == 4'h0)
    else $error("frame did not take sixteen clock edges");
  a_done_sticky:
    assert property (done_flag[0] && !done_clr[0] |=> done_flag[0])
    else $error("done flag lost without clear");
  a_last_bit:
    assert property ($rose(done_flag[0]) && so_oe[0] |-> $stable(so_o[0]))
    else $error("data out moved at frame end");
  a_select_freeze:
    assert property (ss_in_b && $past(ss_in_b) && !$past(wr) &&
      !$past(wr, 2) && !sck_oe[1] |-> $stable(so_o[1]))
    else $error("channel 1 moved while deselected");
endmodule
bind csp_top csp_props i_csp_props (.clk(clk), .rst_b(rst_b),
  .addr(addr), .wdata(wdata), .wr(wr), .ss_in_b(ss_in_b), .sck_o(sck_o),
  .sck_oe(sck_oe), .so_o(so_o), .so_oe(so_oe), .done_flag(done_flag),
  .done_clr(done_clr));

// ### tb/csp_peer.sv
// peer device on channel 0: samples data out, answers one byte a frame
// assumes clock idles high, data moves on falling, sampled on rising
`timescale 1ns/1ps
module csp_peer (
  input  wire       sck,
  input  wire       so,
  input  wire       en,
  input  wire [7:0] tx_byte,
  output reg        si,
  output reg  [7:0] rx_byte,
  output reg  [7:0] rx_cnt
);
  reg [7:0] sh_reg;
  reg [2:0] n_reg;
  initial begin
    si      = 1'h0;
    rx_byte = 8'h00;
    rx_cnt  = 8'h00;
    sh_reg  = 8'h00;
    n_reg   = 3'h0;
  end
  always @(negedge sck) begin
    if (en)
      si <= tx_byte[3'h7 - n_reg];
  end
  // sample data out; an aborted frame restarts the count
  always @(posedge sck or negedge en) begin
    if (!en) begin
      n_reg <= 3'h0;
    end else begin
      sh_reg <= {sh_reg[6:0], so};
      n_reg  <= n_reg + 3'h1;
      if (n_reg == 3'h7) begin
        rx_byte <= {sh_reg[6:0], so};
        rx_cnt  <= rx_cnt + 8'h1;
        si      <= ~si; // line released: never the last value
      end
    end
  end
endmodule

// ### tb/test_three_wire_clocked_serial_port.sv
// bench for the two-channel clocked serial port
// assumes the peer answers channel 0; the bench clocks channel 1 as slave
`timescale 1ns/1ps
module test_three_wire_clocked_serial_port;
  reg         clk, rst_b, wr, rd, ss_in_b, sck1, si1;
  reg  [15:0] addr;
  reg  [7:0]  wdata, tx_byte, d;
  reg  [1:0]  done_clr;
  wire [7:0]  rdata, rx_byte, rx_cnt;
  wire [1:0]  sck_o, sck_oe, so_o, so_oe, done_flag, tx_ready;
  wire        si;
  integer     err_count, total_checks, i;
  csp_top i_csp_top (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .sck_in({sck1, 1'h1}),
    .si_in({si1, si}),
    .ss_in_b(ss_in_b), .sck_o(sck_o), .sck_oe(sck_oe), .so_o(so_o),
    .so_oe(so_oe), .done_flag(done_flag), .done_clr(done_clr),
    .tx_ready(tx_ready));
  csp_peer i_csp_peer (.sck(sck_o[0]), .so(so_o[0]), .en(sck_oe[0]),
    .tx_byte(tx_byte), .si(si), .rx_byte(rx_byte), .rx_cnt(rx_cnt));
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  task finish_test;
    begin
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task chk(input [8*8-1:0] n, input [7:0] e, input [7:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("ERROR %0s exp %h got %h", n, e, g);
      end
    end
  endtask
  // one strobe cycle, inputs moved 5 ns after the edge
  task acc(input w, input [15:0] a, input [7:0] v);
    begin
      @(posedge clk);
      #5;
      addr  = a;
      wdata = v;
      wr    = w;
      rd    = ~w;
      @(posedge clk);
      #5;
      wr = 1'h0;
      rd = 1'h0;
      d  = rdata;
    end
  endtask
  // bounded wait for the peer to finish frame n
  task wait_rx(input [7:0] n);
    integer k;
    begin
      k = 0;
      while (rx_cnt !== n && k < 4000) begin
        @(posedge clk);
        k = k + 1;
      end
      if (k == 4000) begin
        err_count = err_count + 1;
        $display("ERROR frame exp %h got %h", n, rx_cnt);
        finish_test;
      end
    end
  endtask
  // channel 1 slave clock, idle high: the top n bits of v, msb first
  task slv(input [7:0] v, input integer n);
    integer j;
    begin
      for (j = 0; j < n; j = j + 1) begin
        @(posedge clk);
        #5;
        sck1 = 1'h0;
        si1  = v[7 - j];
        repeat (3) @(posedge clk);
        #5;
        sck1 = 1'h1;
        repeat (3) @(posedge clk);
        #5;
      end
    end
  endtask
  initial begin
    rst_b = 1'h0;
    wr = 1'h0;
    rd = 1'h0;
    ss_in_b = 1'h1;
    sck1 = 1'h1;
    si1 = 1'h0;
    addr = 16'h0000;
    wdata = 8'h00;
    done_clr = 2'h0;
    tx_byte = 8'h3C;
    err_count = 0;
    total_checks = 0;
    repeat (16) @(posedge clk);
    #5;
    rst_b = 1'h1;
    acc(1'h0, 16'hFF88, 8'h00);
    chk("mode1", 8'h00, d);
    acc(1'h0, 16'hFF81, 8'h00);
    chk("clksel", 8'h00, d);
    chk("pins", 8'h00, {2'h0, sck_oe, so_oe, done_flag});
    // slowest master clock keeps the queue full while the first frame runs
    // polarity stays 0
    acc(1'h1, 16'hFF81, 8'h06);
    acc(1'h1, 16'hFF80, 8'hC0);
    for (i = 0; i < 5; i = i + 1)
      acc(1'h1, 16'hFF83, {i[3:0], ~i[3:0]});
    repeat (4) @(posedge clk);
    chk("full", 8'h00, {7'h0, tx_ready[0]});
    acc(1'h1, 16'hFF83, 8'h77);
    for (i = 0; i < 5; i = i + 1) begin
      wait_rx(i[7:0] + 8'h1);
      chk("peer", {i[3:0], ~i[3:0]}, rx_byte);
    end
    repeat (1200) @(posedge clk);
    chk("count", 8'h05, rx_cnt);
    chk("done", 8'h01, {7'h0, done_flag[0]});
    chk("last", 8'h01, {7'h0, so_o[0]});
    acc(1'h0, 16'hFF82, 8'h00);
    chk("rx", 8'h3C, d);
    acc(1'h0, 16'hFF80, 8'h00);
    chk("idle", 8'hC0, d);
    done_clr = 2'h1;
    @(posedge clk);
    #5;
    done_clr = 2'h0;
    chk("clr", 8'h00, {7'h0, done_flag[0]});
    // lsb first both ways
    tx_byte = 8'h35;
    acc(1'h1, 16'hFF80, 8'hD0);
    acc(1'h1, 16'hFF83, 8'h01);
    wait_rx(8'h06);
    chk("lsb tx", 8'h80, rx_byte);
    acc(1'h0, 16'hFF82, 8'h00);
    chk("lsb rx", 8'hAC, d);
    // receive only, started by reading the shifter
    tx_byte = 8'h96;
    acc(1'h1, 16'hFF80, 8'h80);
    @(posedge clk);
    #5;
    chk("rx pins", 8'h00, {6'h0, so_o[0], so_oe[0]});
    acc(1'h0, 16'hFF82, 8'h00);
    wait_rx(8'h07);
    acc(1'h0, 16'hFF82, 8'h00);
    chk("rx only", 8'h96, d);
    // the read re-armed a frame: stop it midway
    repeat (100) @(posedge clk);
    acc(1'h1, 16'hFF80, 8'h20);
    acc(1'h0, 16'hFF80, 8'h00);
    chk("stop", 8'h00, d);
    chk("stop pin", 8'h00, {7'h0, sck_oe[0]});
    acc(1'h0, 16'hFF82, 8'h00);
    chk("stop sh", 8'h00, d);
    // channel 1 slave with select: held, then started
    acc(1'h1, 16'hFF89, 8'h07);
    acc(1'h1, 16'hFF88, 8'hE0);
    acc(1'h1, 16'hFF8B, 8'hAA);
    repeat (20) @(posedge clk);
    acc(1'h0, 16'hFF88, 8'h00);
    chk("held", 8'hE0, d);
    ss_in_b = 1'h0;
    repeat (5) @(posedge clk);
    acc(1'h0, 16'hFF88, 8'h00);
    chk("started", 8'hE1, d);
    // four bits, two bits (four edges) lost while deselected, then the last four
    slv(8'hC0, 4);
    ss_in_b = 1'h1;
    repeat (4) @(posedge clk);
    slv(8'hFF, 2);
    ss_in_b = 1'h0;
    repeat (4) @(posedge clk);
    slv(8'h50, 4);
    chk("ch1 done", 8'h01, {7'h0, done_flag[1]});
    acc(1'h0, 16'hFF8A, 8'h00);
    chk("ch1 rx", 8'hC5, d);
    acc(1'h0, 16'hFF88, 8'h00);
    chk("ch1 idle", 8'hE0, d);
    ss_in_b = 1'h1;
    acc(1'h1, 16'hFF88, 8'h00);
    acc(1'h0, 16'hFF88, 8'h00);
    chk("ch1 stop", 8'h00, d);
    finish_test;
  end
endmodule
